// File: pkg/wdw_pkg.sv
// constants and lookups shared by the windowed watchdog modules
package wdw_pkg;

  // ==========================================================
  // control word layout
  localparam int          CTRL_W        = 8;
  localparam int          ACT_POS       = 7;
  localparam int          TOP_POS       = 6;
  localparam int          CNT_W         = 6;
  localparam logic [7:0]  CTRL_RST_VAL  = 8'h7f;

  // ==========================================================
  // prescaler timing, in oscillator cycles
  localparam int          TICK_CYCLES   = 16384;
  localparam int          STEP_CYCLES   = 64;
  localparam int          MIN_BASE      = 128;
  localparam int          SHORT_BASE    = 192;
  localparam int          PERIOD_STEPS  = TICK_CYCLES / STEP_CYCLES;
  localparam int          PRE_W         = 15;
  localparam int          ACC_W         = 7;
  localparam int          ACC_STEP      = 4;

  // ==========================================================
  // reset pin pulse
  localparam int          CLK_PERIOD_NS = 8;
  localparam int          RST_PULSE_NS  = 500;
  localparam int          RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          PULSE_W       = 7;

  // ==========================================================
  // reset cause bits
  localparam int          CAUSE_W       = 3;
  localparam int          CAUSE_TIMEOUT = 0;
  localparam int          CAUSE_SOFT    = 1;
  localparam int          CAUSE_HALT    = 2;

  typedef logic [1:0] wdw_tb_t;

  // timebase correction constants per select code
  function automatic logic [5:0] wdw_msb(input wdw_tb_t sel);
    unique case (sel)
      2'h0:    wdw_msb = 6'h04;
      2'h1:    wdw_msb = 6'h08;
      2'h2:    wdw_msb = 6'h14;
      default: wdw_msb = 6'h31;
    endcase
  endfunction

  function automatic logic [5:0] wdw_lsb(input wdw_tb_t sel);
    unique case (sel)
      2'h0:    wdw_lsb = 6'h3b;
      2'h1:    wdw_lsb = 6'h35;
      2'h2:    wdw_lsb = 6'h23;
      default: wdw_lsb = 6'h36;
    endcase
  endfunction

endpackage

// File: pkg/wdw_pre_if.sv
// carrier between the watchdog core and its prescaler
`timescale 1ns/1ns
interface wdw_pre_if;
  import wdw_pkg::*;

  logic            ce;
  logic            wr;
  logic [1:0]      tb_sel;
  logic            tick;

  modport core (output ce, output wr, output tb_sel, input tick);
  modport pre  (input ce, input wr, input tb_sel, output tick);
endinterface

// File: logic/wdw_prescaler.sv
// free-running prescaler producing counter decrement ticks
`timescale 1ns/1ns
module wdw_prescaler
  import wdw_pkg::*;
#(
  parameter int TICK = TICK_CYCLES
) (
  // clock and reset
  input  wire logic CLOCK,
  input  wire logic RST,
  // core side
  wdw_pre_if.pre    bus
);

  logic [PRE_W-1:0] rem_q,  rem_d;
  logic [ACC_W-1:0] acc_q,  acc_d;
  logic             tick_q, tick_d;
  logic [PRE_W-1:0] long_len;
  logic [PRE_W-1:0] short_len;
  logic [PRE_W-1:0] min_len;
  logic [5:0]       msb;
  logic [5:0]       lsb;
  logic [ACC_W-1:0] acc_add;

  assign msb = wdw_msb(bus.tb_sel);
  assign lsb = wdw_lsb(bus.tb_sel);
  // scaled against TICK so a shortened simulation keeps the proportions
  assign long_len  = PRE_W'(TICK);
  assign short_len = PRE_W'((TICK / PERIOD_STEPS) * (SHORT_BASE + int'(lsb)));
  assign min_len   = PRE_W'((TICK / PERIOD_STEPS) * (MIN_BASE + int'(lsb)));
  assign acc_add   = acc_q + ACC_W'(ACC_STEP);
  assign bus.tick  = tick_q;

  // ==========================================================
  // period counter
  always_comb begin
    rem_d  = rem_q;
    acc_d  = acc_q;
    // a tick waiting while the clock enable is low is kept, not lost
    tick_d = bus.ce ? 1'b0 : tick_q;
    if (bus.ce) begin
      if (rem_q <= PRE_W'(1)) begin
        tick_d = 1'b1;
        // of n periods, floor(4n/msb) are shortened; floor by subtraction
        if (acc_add >= ACC_W'(msb)) begin
          acc_d = acc_add - ACC_W'(msb);
          rem_d = short_len;
        end else begin
          acc_d = acc_add;
          rem_d = long_len;
        end
      end else begin
        rem_d = rem_q - PRE_W'(1);
      end
      // a refresh never restarts the prescaler, it only enforces the minimum;
      // the shortening pattern does restart, so n steps hold exactly
      // floor(4n/msb) short periods, and a tick due on this edge is dropped
      if (bus.wr) begin
        tick_d = 1'b0;
        acc_d  = '0;
        if (rem_d < min_len) begin
          rem_d = min_len;
        end
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rem_q  <= PRE_W'(TICK);
      acc_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      rem_q  <= rem_d;
      acc_q  <= acc_d;
      tick_q <= tick_d;
    end
  end

endmodule // wdw_prescaler

// File: logic/wdw_watchdog.sv
// windowed down-counter watchdog core
//
// Operation
// - decrement counter every 16384 oscillator cycles
// - active and 40h to 3Fh: pulse reset pin
// - counter runs except while halted, inactive only blocks reset
// - reset leaves inactive; activation bit set-only
// - write with activation, top bit clear: reset
// - active watchdog resets on halt instruction when the halt reset option is set
// - lower six bits give 64 timeout steps
// - timeout spans minimum to maximum, unknown phase
// - base minimum (LSB+128)x64, maximum 16384 oscillator cycles
// - timebase select picks MSB/LSB pair
// - periodic shortened periods per floor(4n/MSB)
// - option inputs: hardware watchdog, halt reset
// - control register resets to 7Fh
// - hardware option forces active, ignores bit
// - divisions round down, except the pulse length, which rounds up
`timescale 1ns/1ns
module wdw_watchdog
  import wdw_pkg::*;
#(
  parameter int TICK = TICK_CYCLES
) (
  // clock, reset, enable
  input  wire logic              CLOCK,
  input  wire logic              RST,
  input  wire logic              CE,
  // control register write port
  input  wire logic              CTRL_WR,
  input  wire logic [CTRL_W-1:0] CTRL_WDATA,
  // cpu events
  input  wire logic              HALT_EXEC,
  input  wire logic              WAKE_EVT,
  // configuration
  input  wire logic [1:0]        TIMEBASE_SELECT,
  input  wire logic              HW_WDG_OPTION,
  input  wire logic              HALT_RESET_OPTION,
  // status
  output logic      [CTRL_W-1:0] CTRL_RDATA,
  output logic                   WDG_ACTIVE,
  output logic                   DEC_TICK,
  output logic      [CAUSE_W-1:0] RESET_CAUSE,
  // open-drain reset pin
  output logic                   RST_PIN_O,
  output logic                   RST_PIN_OE
);

  typedef enum logic [1:0] {
    WDW_BOOT,
    WDW_RUN,
    WDW_PULSE
  } wdw_state_e;

  // ==========================================================
  // prescaler
  wdw_pre_if pre_bus ();

  wdw_prescaler #(
    .TICK (TICK)
  ) u_pre (
    .CLOCK (CLOCK),
    .RST   (RST),
    .bus   (pre_bus)
  );

  // ==========================================================
  // state
  wdw_state_e           state_q,  state_d;
  logic                 act_q,    act_d;
  logic [6:0]           cnt_q,    cnt_d;
  logic                 hw_opt_q, hw_opt_d;
  logic                 halt_opt_q, halt_opt_d;
  logic                 halted_q, halted_d;
  logic [PULSE_W-1:0]   pulse_q,  pulse_d;
  logic [CAUSE_W-1:0]   cause_q,  cause_d;
  logic [CTRL_W-1:0]    rdata_q,  rdata_d;
  logic                 active_o_q, active_o_d;
  logic                 tick_o_q, tick_o_d;
  logic                 pin_oe_q, pin_oe_d;

  logic                 wr_en;
  logic                 tick_en;
  logic                 active_now;
  logic                 active_next;
  logic                 fire_timeout;
  logic                 fire_soft;
  logic                 fire_halt;

  assign pre_bus.ce     = CE;
  assign pre_bus.wr     = wr_en;
  assign pre_bus.tb_sel = TIMEBASE_SELECT;

  assign wr_en   = CE && CTRL_WR && state_q == WDW_RUN;
  assign tick_en = CE && pre_bus.tick && state_q == WDW_RUN;

  // ==========================================================
  // control register and trigger decode
  always_comb begin
    act_d        = act_q;
    cnt_d        = cnt_q;
    halted_d     = halted_q;
    fire_timeout = 1'b0;
    fire_soft    = 1'b0;
    fire_halt    = 1'b0;
    active_now   = act_q || hw_opt_q;
    active_next  = active_now;

    if (CE && state_q == WDW_RUN) begin
      // the counter keeps running regardless of activation
      if (tick_en && !halted_q) begin
        cnt_d = cnt_q - 7'h01;
      end
      if (wr_en) begin
        act_d = act_q | CTRL_WDATA[ACT_POS];
        cnt_d = CTRL_WDATA[TOP_POS:0];
      end
      active_next = act_d || hw_opt_q;

      if (HALT_EXEC && !halted_q) begin
        if (active_now && halt_opt_q) begin
          fire_halt = 1'b1;
        end else begin
          // halt without reset: one last decrement, then the counter sleeps
          halted_d = 1'b1;
          // a tick on this same edge already is that one decrement
          if (wr_en || !tick_en) begin
            cnt_d = cnt_d - 7'h01;
          end
        end
      end else if (halted_q && WAKE_EVT) begin
        halted_d = 1'b0;
      end

      // halt wins as cause, so the cause field stays one-hot
      if (!fire_halt && wr_en && active_next && !CTRL_WDATA[TOP_POS]) begin
        fire_soft = 1'b1;
      end else if (!fire_halt && active_now && cnt_q[TOP_POS] && !cnt_d[TOP_POS]) begin
        fire_timeout = 1'b1;
      end
    end
  end

  // ==========================================================
  // sequencer: options capture, run, reset pulse
  always_comb begin
    state_d    = state_q;
    pulse_d    = pulse_q;
    cause_d    = cause_q;
    hw_opt_d   = hw_opt_q;
    halt_opt_d = halt_opt_q;
    if (CE) begin
      unique case (state_q)
        WDW_BOOT: begin
          // non-volatile options are sampled in every boot cycle, after reset release and after each pulse
          hw_opt_d   = HW_WDG_OPTION;
          halt_opt_d = HALT_RESET_OPTION;
          state_d    = WDW_RUN;
        end
        WDW_RUN: begin
          if (fire_timeout || fire_soft || fire_halt) begin
            state_d = WDW_PULSE;
            pulse_d = PULSE_W'(RST_PULSE_CYC - 1);
            cause_d = {fire_halt, fire_soft, fire_timeout};
          end
        end
        WDW_PULSE: begin
          if (pulse_q == '0) begin
            state_d = WDW_BOOT;
          end else begin
            pulse_d = pulse_q - PULSE_W'(1);
          end
        end
      endcase
    end
  end

  // ==========================================================
  // output staging
  always_comb begin
    rdata_d    = {act_d, cnt_d};
    // options captured in the boot cycle show at once
    active_o_d = active_next || hw_opt_d;
    tick_o_d   = tick_en && !halted_q;
    pin_oe_d   = state_d == WDW_PULSE;
    if (state_d == WDW_BOOT) begin
      rdata_d    = CTRL_RST_VAL;
      active_o_d = 1'b0;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_q    <= WDW_BOOT;
      act_q      <= CTRL_RST_VAL[ACT_POS];
      cnt_q      <= CTRL_RST_VAL[TOP_POS:0];
      hw_opt_q   <= 1'b0;
      halt_opt_q <= 1'b0;
      halted_q   <= 1'b0;
      pulse_q    <= '0;
      cause_q    <= '0;
      rdata_q    <= CTRL_RST_VAL;
      active_o_q <= 1'b0;
      tick_o_q   <= 1'b0;
      pin_oe_q   <= 1'b0;
    end else if (CE) begin
      state_q    <= state_d;
      hw_opt_q   <= hw_opt_d;
      halt_opt_q <= halt_opt_d;
      pulse_q    <= pulse_d;
      cause_q    <= cause_d;
      rdata_q    <= rdata_d;
      active_o_q <= active_o_d;
      tick_o_q   <= tick_o_d;
      pin_oe_q   <= pin_oe_d;
      // the watchdog's own reset returns the control register and halt flag to their post-reset values
      if (state_d == WDW_BOOT) begin
        act_q    <= CTRL_RST_VAL[ACT_POS];
        cnt_q    <= CTRL_RST_VAL[TOP_POS:0];
        halted_q <= 1'b0;
      end else begin
        act_q    <= act_d;
        cnt_q    <= cnt_d;
        halted_q <= halted_d;
      end
    end else begin
      tick_o_q <= 1'b0;
    end
  end

  assign CTRL_RDATA  = rdata_q;
  assign WDG_ACTIVE  = active_o_q;
  assign DEC_TICK    = tick_o_q;
  assign RESET_CAUSE = cause_q;
  assign RST_PIN_O   = 1'b0;
  assign RST_PIN_OE  = pin_oe_q;

endmodule // wdw_watchdog

// File: bench/wdw_watchdog_checker.sv
// concurrent checks on the watchdog top ports
`timescale 1ns/1ns
module wdw_watchdog_checker
  import wdw_pkg::*;
#(
  parameter int TICK = TICK_CYCLES
) (
  // clock and controls
  input wire logic               CLOCK,
  input wire logic               RST,
  input wire logic               CE,
  input wire logic               CTRL_WR,
  input wire logic [CTRL_W-1:0]  CTRL_WDATA,
  input wire logic               HALT_EXEC,
  // status and pin
  input wire logic [CTRL_W-1:0]  CTRL_RDATA,
  input wire logic               WDG_ACTIVE,
  input wire logic               DEC_TICK,
  input wire logic [CAUSE_W-1:0] RESET_CAUSE,
  input wire logic               RST_PIN_O,
  input wire logic               RST_PIN_OE
);
  // ==========================================
  // pulse length counter
  logic [6:0] oe_cnt_q;
  logic [6:0] oe_cnt_d;
  always_comb oe_cnt_d = (RST || !RST_PIN_OE) ? 7'h00 : oe_cnt_q + 7'h01;
  always_ff @(posedge CLOCK) oe_cnt_q <= oe_cnt_d;

  // ==========================================
  // properties
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // boot cycles after a reset or a pulse ignore writes
  sequence s_wr_ok;
    CTRL_WR && CE && !HALT_EXEC && !RST_PIN_OE && !$past(RST_PIN_OE)
      && !$past(RST_PIN_OE, 2) && !$past(RST);
  endsequence
  AST_RST_VAL: assert property (disable iff (1'b0) RST |=> CTRL_RDATA == CTRL_RST_VAL
    && !WDG_ACTIVE && !RST_PIN_OE && RESET_CAUSE == 3'h0) else $error("bad reset state");
  AST_WR_LOAD: assert property (s_wr_ok ##0 CTRL_WDATA[TOP_POS] |=>
    CTRL_RDATA[6:0] == $past(CTRL_WDATA[6:0])
    && WDG_ACTIVE == $past(WDG_ACTIVE || CTRL_WDATA[ACT_POS])) else $error("write not loaded");
  AST_SOFT: assert property (s_wr_ok ##0 !CTRL_WDATA[TOP_POS]
    && (WDG_ACTIVE || CTRL_WDATA[ACT_POS]) |=> RST_PIN_OE && RESET_CAUSE == 3'h2)
    else $error("no software reset");
  AST_ACT_HOLD: assert property (WDG_ACTIVE && !RST_PIN_OE ##1 !RST_PIN_OE |-> WDG_ACTIVE)
    else $error("activation lost");
  AST_IDLE: assert property (!WDG_ACTIVE && !RST_PIN_OE && !CTRL_WR |=> !RST_PIN_OE)
    else $error("reset while inactive");
  AST_PULSE_LEN: assert property ($fell(RST_PIN_OE) |-> oe_cnt_q == 7'h3f)
    else $error("pulse length wrong");
  AST_PULSE_MAX: assert property (RST_PIN_OE |-> oe_cnt_q < 7'h3f) else $error("pulse too long");
  AST_TICK_ONE: assert property (DEC_TICK |=> !DEC_TICK) else $error("tick too wide");
  AST_TICK_DEC: assert property (DEC_TICK && !$past(CTRL_WR) && !RST_PIN_OE &&
    !$past(RST_PIN_OE) |-> CTRL_RDATA[6:0] == $past(CTRL_RDATA[6:0]) - 7'h01)
    else $error("tick without decrement");
  AST_TIMEOUT: assert property (WDG_ACTIVE && DEC_TICK && !$past(CTRL_WR) &&
    CTRL_RDATA[6:0] == 7'h3f |->
    ##[0:1] (RST_PIN_OE && RESET_CAUSE[CAUSE_TIMEOUT])) else $error("no timeout reset");
  AST_OD_LOW: assert property (RST_PIN_OE |-> !RST_PIN_O) else $error("pin not low");
endmodule // wdw_watchdog_checker

bind wdw_watchdog wdw_watchdog_checker #(.TICK(TICK)) wdw_watchdog_checker_inst (
  .CLOCK(CLOCK), .RST(RST), .CE(CE), .CTRL_WR(CTRL_WR), .CTRL_WDATA(CTRL_WDATA),
  .HALT_EXEC(HALT_EXEC), .CTRL_RDATA(CTRL_RDATA), .WDG_ACTIVE(WDG_ACTIVE),
  .DEC_TICK(DEC_TICK), .RESET_CAUSE(RESET_CAUSE), .RST_PIN_O(RST_PIN_O),
  .RST_PIN_OE(RST_PIN_OE));

// File: bench/wdw_watchdog_tb_top.sv
// self-checking bench for the windowed watchdog
`timescale 1ns/1ns
module wdw_watchdog_tb_top;
  import wdw_pkg::*;
  localparam int TK = 256;
  logic        clock = 1'b0, rst = 1'b1, ce = 1'b1, wr = 1'b0, halt = 1'b0, wake = 1'b0;
  logic        hw = 1'b0, hro = 1'b1, act, tick, oe, od;
  logic [1:0]  tbs = 2'h0;
  logic [7:0]  wdata = 8'h00, rdata;
  logic [2:0]  cause;
  logic [15:0] rnd = 16'h0001;
  int          err_total = 0, tests_run = 0, exp_q, n, t, lo, hi;
  int          mt[4] = '{4, 8, 20, 49};
  int          lt[4] = '{59, 53, 35, 54};

  wdw_watchdog #(.TICK(TK)) wdw_watchdog_inst (.CLOCK(clock), .RST(rst), .CE(ce),
    .CTRL_WR(wr), .CTRL_WDATA(wdata), .HALT_EXEC(halt), .WAKE_EVT(wake),
    .TIMEBASE_SELECT(tbs), .HW_WDG_OPTION(hw), .HALT_RESET_OPTION(hro),
    .CTRL_RDATA(rdata), .WDG_ACTIVE(act), .DEC_TICK(tick), .RESET_CAUSE(cause),
    .RST_PIN_O(od), .RST_PIN_OE(oe));

  initial forever #4 clock = ~clock;

  // ==========================================
  // helpers
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // le picks the inclusive comparison used by the upper bound
  function automatic int tmo(input int m, input int l, input int c, input bit le);
    int k;
    k = 4 * c / m;
    if (c < m / 4 || (le && c == m / 4)) k = 0;
    return TK * (c - k) + (192 + l) * TK / 256 * k;
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] expd);
    tests_run++;
    if (seen !== expd) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, expd);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask
  task automatic wr_reg(input logic [7:0] v);
    cyc(1);
    wr = 1'b1;
    wdata = v;
    cyc(1);
    wr = 1'b0;
  endtask
  task automatic pulse_in(input logic [2:0] v);
    cyc(1);
    if (v[0]) begin
      halt = 1'b1;
    end else begin
      wake = 1'b1;
    end
    cyc(1);
    halt = 1'b0;
    wake = 1'b0;
  endtask
  // a tick seen right after the write edge was overwritten by the write
  task automatic wait_oe(input int lim, output int c);
    c = 0;
    do begin
      cyc(1);
      c++;
      if (c > 1 && tick === 1'b1 && oe !== 1'b1) begin
        exp_q = (exp_q & 'h80) | ((exp_q - 1) & 'h7f);
        chk(rdata, exp_q[7:0]);
      end
    end while (oe !== 1'b1 && c < lim);
  endtask
  task automatic pulse(input logic [2:0] ec);
    chk({5'h00, cause}, {5'h00, ec});
    cyc(63);
    chk({7'h00, oe}, 8'h00);
    chk(rdata, 8'h7f);
    cyc(2);
    chk({7'h00, act}, {7'h00, hw});
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================
  // scenarios
  initial begin
    cyc(20);
    rst = 1'b0;
    cyc(2);
    chk(rdata, 8'h7f);
    chk({act, cause, oe, 3'h0}, 8'h00);
    pulse_in(3'h1);
    chk({7'h00, oe}, 8'h00);
    pulse_in(3'h0);
    wr_reg(8'hc5);
    chk(rdata, 8'hc5);
    ce = 1'b0;
    wr_reg(8'h7e);
    chk(rdata, 8'hc5);
    ce = 1'b1;
    wr_reg(8'h7e);
    chk(rdata, 8'hfe);
    wr_reg(8'h80);
    chk({7'h00, oe}, 8'h01);
    pulse(3'h2);
    wr_reg(8'h41);
    exp_q = 'h41;
    wait_oe(4 * TK, t);
    chk({7'h00, oe, exp_q < 'h40}, 8'h01);
    for (int s = 0; s < 4; s++) begin
      tbs = s[1:0];
      rnd = lfsr(rnd);
      n = rnd[3:0];
      lo = (lt[s] + 128) * TK / 256 + tmo(mt[s], lt[s], n, 1'b0);
      hi = TK + tmo(mt[s], lt[s], n, 1'b1);
      wr_reg(8'hc0 | {4'h0, rnd[3:0]});
      exp_q = 'hc0 | n;
      chk(rdata, exp_q[7:0]);
      wait_oe(hi + 8, t);
      chk({7'h00, t >= lo - 2 && t <= hi + 4}, 8'h01);
      pulse(3'h1);
    end
    wr_reg(8'hff);
    pulse_in(3'h1);
    chk({7'h00, oe}, 8'h01);
    hro = 1'b0;
    pulse(3'h4);
    wr_reg(8'hc2);
    pulse_in(3'h1);
    cyc(3 * TK);
    chk({oe, rdata[6:0]}, 8'h41);
    pulse_in(3'h0);
    hw = 1'b1;
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    cyc(2);
    chk({7'h00, act}, 8'h01);
    wr_reg(8'h3f);
    chk({7'h00, oe}, 8'h01);
    pulse(3'h2);
    end_of_test;
  end

  initial begin
    cyc(60000);
    err_total++;
    end_of_test;
  end
endmodule // wdw_watchdog_tb_top
